// ---- design/vadc_regs.svh ----
`ifndef VADC_REGS_SVH
`define VADC_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define VADC_CTRL_ADDR       4'h0
`define VADC_STAT_ADDR       4'h4
`define VADC_SAMPLE_ADDR     4'h8
`define VADC_CLAMP_ADDR      4'hC

// ****************************************
// control fields
// ****************************************
`define VADC_CTRL_SEL_LO     0
`define VADC_CTRL_SEL_HI     1
`define VADC_CTRL_LEVEL_BIT  2
`define VADC_CTRL_FORMAT_BIT 3
`define VADC_CTRL_ENABLE_BIT 4
`define VADC_CTRL_PULSE_BIT  5
`define VADC_CTRL_RESET      6'h10

// ****************************************
// clamp references and codes
// ****************************************
`define VADC_REF_HIGH        8'h80
`define VADC_REF_LOW         8'h10
`define VADC_CODE_MIN        8'h00
`define VADC_CODE_MAX        8'hFF
`define VADC_CLAMP_UA        50
`define VADC_CLK_MAX_MHZ     30

`endif

// ---- design/vadc_pkg.sv ----
package vadc_pkg;
    typedef enum logic [1:0] {
        VADC_CLAMP_OFF,
        VADC_CLAMP_SOURCE,
        VADC_CLAMP_SINK
    } vadc_clamp_t;

    // first member is the top bit: select sits in bits 1:0, clamp pulse in bit 5
    typedef struct packed {
        logic       clamp_pulse;
        logic       sample_output_enable_n;
        logic       output_format_select;
        logic       clamp_level_select;
        logic [1:0] sel;
    } vadc_ctrl_t;

    typedef struct packed {
        logic       underflow;
        logic       overflow;
        logic [8:0] level;
    } vadc_raw_t;
endpackage : vadc_pkg

// ---- design/vadc_code.sv ----
`timescale 1ns/1ps
`include "vadc_regs.svh"
module vadc_code
    import vadc_pkg::*;
(
    // raw conversion result
    input  wire vadc_raw_t  raw,
    input  wire logic       twos,
    // coded sample
    output logic [7:0]      bin_code,
    output logic [7:0]      out_code
);
    always_comb begin
        if (raw.underflow) begin
            bin_code = `VADC_CODE_MIN;
        end else if (raw.overflow || raw.level[8]) begin
            bin_code = `VADC_CODE_MAX;
        end else begin
            bin_code = raw.level[7:0];
        end
        out_code = twos ? {~bin_code[7], bin_code[6:0]} : bin_code;
    end
endmodule : vadc_code

// ---- design/vadc_ctl.sv ----
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "vadc_regs.svh"
module vadc_ctl
    import vadc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // converter side
    input  wire vadc_raw_t   conv_raw,
    input  wire logic        conv_valid,
    // pins
    output logic             input_select_low_bit,
    output logic             input_select_high_bit,
    output logic [1:0]       video_input_route,
    output vadc_clamp_t      clamp_current,
    output logic [7:0]       sample_code_bits,
    output logic [7:0]       sample_code_bits_oe_n,
    output logic             sample_valid
);
    vadc_ctrl_t  ctrl_r, ctrl_nxt;
    logic [7:0]  code_r, code_nxt;
    logic [7:0]  bin_r, bin_nxt;
    logic        valid_r, valid_nxt;
    logic [1:0]  route_r, route_nxt;
    vadc_clamp_t clamp_r, clamp_nxt;
    logic [7:0]  oe_n_r, oe_n_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        ack_r, ack_nxt;
    logic [7:0]  bin_code;
    logic [7:0]  out_code;
    logic [7:0]  ref_lvl;

    // ****************************************
    // sample coding
    // ****************************************
    vadc_code u_code (
        .raw      (conv_raw),
        .twos     (ctrl_r.output_format_select),
        .bin_code (bin_code),
        .out_code (out_code)
    );

    function automatic logic [1:0] route_of(input logic [1:0] sel);
        case (sel)
            2'h0:    route_of = 2'h0;
            2'h2:    route_of = 2'h2;
            default: route_of = 2'h1;
        endcase
    endfunction : route_of

    // ****************************************
    // datapath and clamp
    // ****************************************
    always_comb begin
        ref_lvl   = ctrl_r.clamp_level_select ? `VADC_REF_HIGH : `VADC_REF_LOW;
        route_nxt = route_of(ctrl_r.sel);
        code_nxt  = code_r;
        bin_nxt   = bin_r;
        valid_nxt = conv_valid;
        if (conv_valid) begin
            code_nxt = out_code;
            bin_nxt  = bin_code;
        end
        // clamp compares the binary sample, not the output format
        if (!ctrl_r.clamp_pulse) begin
            clamp_nxt = VADC_CLAMP_OFF;
        end else if (bin_r < ref_lvl) begin
            clamp_nxt = VADC_CLAMP_SOURCE;
        end else if (bin_r > ref_lvl) begin
            clamp_nxt = VADC_CLAMP_SINK;
        end else begin
            clamp_nxt = VADC_CLAMP_OFF;
        end
        oe_n_nxt = {8{ctrl_r.sample_output_enable_n}};
    end

    // ****************************************
    // register slave
    // ****************************************
    always_comb begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = rdata_r;
        ack_nxt   = 1'b0;
        if ((avs_read || avs_write) && !ack_r) begin
            ack_nxt   = 1'b1;
            rdata_nxt = 32'h0000_0000;
            if (avs_address == `VADC_CTRL_ADDR) begin
                rdata_nxt[5:0] = ctrl_r;
                if (avs_write && avs_byteenable[0]) begin
                    ctrl_nxt = vadc_ctrl_t'(avs_writedata[5:0]);
                end
            end else if (avs_address == `VADC_STAT_ADDR) begin
                rdata_nxt[3:0] = {clamp_r, route_r};
            end else if (avs_address == `VADC_SAMPLE_ADDR) begin
                rdata_nxt[15:0] = {bin_r, code_r};
            end else if (avs_address == `VADC_CLAMP_ADDR) begin
                rdata_nxt[7:0] = ref_lvl;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r  <= vadc_ctrl_t'(`VADC_CTRL_RESET);
            code_r  <= 8'h00;
            bin_r   <= 8'h00;
            valid_r <= 1'b0;
            route_r <= 2'h0;
            clamp_r <= VADC_CLAMP_OFF;
            oe_n_r  <= 8'hFF;
            rdata_r <= 32'h0000_0000;
            ack_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            code_r  <= code_nxt;
            bin_r   <= bin_nxt;
            valid_r <= valid_nxt;
            route_r <= route_nxt;
            clamp_r <= clamp_nxt;
            oe_n_r  <= oe_n_nxt;
            rdata_r <= rdata_nxt;
            ack_r   <= ack_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_readdata          = rdata_r;
    assign avs_waitrequest       = ~ack_r;
    assign input_select_low_bit  = ctrl_r.sel[0];
    assign input_select_high_bit = ctrl_r.sel[1];
    assign video_input_route     = route_r;
    assign clamp_current         = clamp_r;
    assign sample_code_bits      = code_r;
    assign sample_code_bits_oe_n = oe_n_r;
    assign sample_valid          = valid_r;
endmodule : vadc_ctl

// ---- verif/vadc_ctl_props.sv ----
`timescale 1ns/1ps
module vadc_ctl_props
    import vadc_pkg::*;
(
    // watched pins
    input logic        mclk,
    input logic        srst,
    input vadc_raw_t   conv_raw,
    input logic        conv_valid,
    input logic        input_select_low_bit,
    input logic        input_select_high_bit,
    input logic [1:0]  video_input_route,
    input vadc_clamp_t clamp_current,
    input logic [7:0]  sample_code_bits,
    input logic [7:0]  sample_code_bits_oe_n
);
    // ****
    // properties
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [1:0] sel;
    assign sel = {input_select_high_bit, input_select_low_bit};
    sequence s_plain;
        conv_valid && !conv_raw.underflow && !conv_raw.overflow && !conv_raw.level[8];
    endsequence
    sequence s_sat;
        conv_valid && (conv_raw.underflow || conv_raw.overflow);
    endsequence
    // a code below both references must never sink, one above both never source
    sequence s_low_done;
        conv_valid && conv_raw.underflow ##1 !conv_valid;
    endsequence
    sequence s_high_done;
        conv_valid && conv_raw.overflow && !conv_raw.underflow ##1 !conv_valid;
    endsequence
    AST_ROUTE: assert property ($stable(sel)[*2] |-> video_input_route == (sel[0] ? 2'h1 : sel))
        else $error("route wrong");
    AST_CLAMP: assert property (clamp_current inside {VADC_CLAMP_OFF, VADC_CLAMP_SOURCE, VADC_CLAMP_SINK})
        else $error("clamp wrong");
    AST_CODE: assert property (s_plain |=> sample_code_bits[6:0] == $past(conv_raw.level[6:0]))
        else $error("code wrong");
    AST_SAT: assert property (s_sat |=> sample_code_bits[6:0] == {7{$past(conv_raw.overflow)}})
        else $error("saturation wrong");
    AST_ENABLE: assert property (sample_code_bits_oe_n inside {8'h00, 8'hFF})
        else $error("enable wrong");
    AST_CLAMP_LOW: assert property (s_low_done |=> clamp_current != VADC_CLAMP_SINK)
        else $error("clamp sinks below reference");
    AST_CLAMP_HIGH: assert property (s_high_done |=> clamp_current != VADC_CLAMP_SOURCE)
        else $error("clamp sources above reference");
endmodule : vadc_ctl_props
bind vadc_ctl vadc_ctl_props u_props (.mclk, .srst, .conv_raw, .conv_valid, .input_select_low_bit,
    .input_select_high_bit, .video_input_route, .clamp_current, .sample_code_bits, .sample_code_bits_oe_n);

// ---- verif/vadc_capture_model.sv ----
`timescale 1ns/1ps
module vadc_capture_model (
    // sample bus
    input  logic       mclk,
    input  logic [7:0] data,
    input  logic [7:0] oe_n,
    input  logic       valid,
    // captured word
    output logic [7:0] word_r
);
    // a floated bus reads as the inverse of the last word, so it never passes
    always_ff @(posedge mclk) begin
        if (valid) begin
            word_r <= (oe_n == 8'h00) ? data : ~word_r;
        end
    end
endmodule : vadc_capture_model

// ---- verif/video_input_adc_control_tb.sv ----
`timescale 1ns/1ps
module video_input_adc_control_tb import vadc_pkg::*; ;
    // ****
    // bench
    // ****
    logic        mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, conv_valid = 1'b0, wt, s_lo, s_hi, sv;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0]  route;
    logic [7:0]  code, oe_n, word, b, r;
    vadc_raw_t   conv_raw = '0, v [9];
    vadc_clamp_t clamp, cl;
    int          fail_count = 0, checks_done = 0, n, c, i;
    vadc_ctl DUT (.mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest(wt), .conv_raw, .conv_valid, .input_select_low_bit(s_lo),
        .input_select_high_bit(s_hi), .video_input_route(route), .clamp_current(clamp),
        .sample_code_bits(code), .sample_code_bits_oe_n(oe_n), .sample_valid(sv));
    vadc_capture_model u_cap (.mclk, .data(code), .oe_n, .valid(sv), .word_r(word));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        for (n = 0; n < 9; n++) begin
            @(posedge mclk);
            if (wt === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 9) begin
            fail_count++;
            end_sim();
        end
    endtask : acc
    task automatic smp(input vadc_raw_t x);
        @(posedge mclk);
        conv_raw <= x;
        conv_valid <= 1'b1;
        @(posedge mclk);
        conv_valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : smp
    initial forever #10 mclk = ~mclk;
    initial begin
        v = '{11'h400, 11'h200, 11'h100, 11'h0, 11'hF, 11'h10, 11'h80, 11'h81, 11'hFF};
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        chk("enable", 8'hFF, oe_n);
        chk("route", 0, route);
        chk("clamp", VADC_CLAMP_OFF, clamp);
        acc(1, 4'h6, 32'h3F);
        // a write with lane 0 disabled must leave the control word alone
        avs_byteenable <= 4'h0;
        acc(1, 4'h0, 32'h3F);
        avs_byteenable <= 4'h1;
        acc(0, 4'h0, 0);
        chk("control", 32'h10, q);
        for (c = 0; c < 4; c++) begin
            acc(1, 4'h0, c);
            acc(0, 4'h4, 0);
            chk("route", c[0] ? 1 : c, q[1:0]);
            chk("select", c[1:0], {s_hi, s_lo});
            chk("enable", 0, oe_n);
        end
        for (c = 0; c < 8; c++) begin
            acc(1, 4'h0, {c[2], 1'b0, c[1:0], 2'b00});
            r = c[0] ? 8'h80 : 8'h10;
            acc(0, 4'hC, 0);
            chk("reference", r, q[7:0]);
            for (i = 0; i < 9; i++) begin
                smp(v[i]);
                b = v[i].underflow ? 8'h00 : v[i].overflow || v[i].level[8] ? 8'hFF : v[i].level[7:0];
                cl = !c[2] || b == r ? VADC_CLAMP_OFF : b < r ? VADC_CLAMP_SOURCE : VADC_CLAMP_SINK;
                acc(0, 4'h8, 0);
                chk("sample", {b, c[1] ? ~b[7] : b[7], b[6:0]}, q[15:0]);
                chk("captured", {c[1] ? ~b[7] : b[7], b[6:0]}, word);
                acc(0, 4'h4, 0);
                chk("clamp", cl, q[3:2]);
            end
        end
        // floated outputs with the clamp pulse low: no capture, no clamp current
        r = word;
        acc(1, 4'h0, 32'h10);
        smp(v[6]);
        chk("enable", 8'hFF, oe_n);
        chk("floated", {~r}, word);
        acc(0, 4'h4, 0);
        chk("clamp", VADC_CLAMP_OFF, q[3:2]);
        end_sim();
    end
endmodule : video_input_adc_control_tb
